//--- common/phy_irq_defs.svh
// register offsets, field positions and reset values of the interrupt logic
`ifndef PHY_IRQ_DEFS_SVH
`define PHY_IRQ_DEFS_SVH

`define ADDR_WIDTH             5
`define DATA_WIDTH             16
`define EVENT_COUNT            7

`define OFS_INTERRUPT_CONTROL  5'h11
`define OFS_EVENT_STATUS       5'h12
`define OFS_FALSE_CARRIER_CNT  5'h14
`define OFS_RX_ERROR_CNT       5'h15

`define CTRL_OUTPUT_ENABLE_BIT 0
`define CTRL_GLOBAL_ENABLE_BIT 1
`define CTRL_TEST_FORCE_BIT    2
`define CTRL_FIELD_WIDTH       3

`define STATUS_PENDING_LSB     8
`define STATUS_ENABLE_LSB      0

`define EV_ENERGY              6
`define EV_LINK                5
`define EV_SPEED               4
`define EV_DUPLEX              3
`define EV_AUTONEG             2
`define EV_FALSE_CARRIER_HALF  1
`define EV_RX_ERROR_HALF       0

`define CTRL_RESET             3'h0
`define EVENT_RESET            7'h00
`define COUNT_WIDTH            8
`define COUNT_RESET            8'h00

`endif

//--- common/phy_irq_pkg.sv
// types shared by the interrupt logic
package phy_irq_pkg;
    typedef logic [6:0]  event_vec_type;
    typedef logic [15:0] reg_word_type;
    typedef logic [4:0]  reg_addr_type;
    typedef enum logic [1:0] {
        sel_none,
        sel_control,
        sel_status,
        sel_counter
    } reg_select_type;
endpackage

//--- rtl/input_sync.sv
// three-stage synchroniser that changes only when the last two stages agree
module input_sync (
    input  wire logic core_clk,   // device clock
    input  wire logic arst_n,     // asynchronous reset, active low
    input  wire logic async_in,   // level from outside the clock domain
    output logic      sync_out    // filtered level
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic out_reg;
    logic agree;

    // stage1 feeds stage2 only; the filter looks at stages 2 and 3
    assign agree    = (stage2_reg == stage3_reg);
    assign sync_out = out_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= 1'b1;
            stage2_reg <= 1'b1;
            stage3_reg <= 1'b1;
            out_reg    <= 1'b1;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (agree) begin
                out_reg <= stage3_reg;
            end
        end
    end
endmodule // input_sync

//--- rtl/event_counter.sv
// saturating event counter, cleared by a read, flags crossing of half range
module event_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,   // device clock
    input  wire logic             arst_n,     // asynchronous reset, active low
    input  wire logic             inc,        // one-cycle count pulse
    input  wire logic             clr,        // clear-when-read pulse
    output logic [WIDTH-1:0]      count,      // current count
    output logic                  half_rise   // pulse: msb goes to one
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             at_max;

    assign at_max = &count_reg;

    // a pulse in the clearing cycle is kept as a count of one
    always_comb begin
        if (clr) begin
            count_next = inc ? WIDTH'(1) : '0;
        end else if (inc && !at_max) begin
            count_next = count_reg + WIDTH'(1);
        end else begin
            count_next = count_reg;
        end
    end

    assign half_rise = count_next[WIDTH-1] & ~count_reg[WIDTH-1];
    assign count     = count_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // event_counter

//--- rtl/phy_event_interrupt_logic.sv
// interrupt control, event latching and shared pin logic of the transceiver
`include "phy_irq_defs.svh"

module phy_event_interrupt_logic #(
    parameter bit IRQ_ACTIVE_LOW = 1'b1
) (
    input  wire logic                       core_clk,        // 10 MHz clock
    input  wire logic                       arst_n,          // reset, low
    input  wire phy_irq_pkg::reg_addr_type  reg_addr,        // register index
    input  wire logic                       reg_rd,          // read pulse
    input  wire logic                       reg_wr,          // write pulse
    input  wire phy_irq_pkg::reg_word_type  reg_wdata,       // write data
    output phy_irq_pkg::reg_word_type       reg_rdata,       // read data
    output logic                            reg_rvalid,      // read done
    input  wire logic                       energy_state,    // energy seen
    input  wire logic                       link_state,      // link up
    input  wire logic                       speed_state,     // 100 Mb/s
    input  wire logic                       duplex_state,    // full duplex
    input  wire logic                       autoneg_done,    // autoneg done
    input  wire logic                       false_carrier_event, // count
    input  wire logic                       rx_error_event,  // count pulse
    input  wire logic                       powerdown_or_irq_pin_i,  // pin in
    output logic                            powerdown_or_irq_pin_o,  // pin out
    output logic                            powerdown_or_irq_pin_oe, // drive
    output logic                            powerdown_request, // pin asks
    output logic                            irq_active       // irq level
);
    // register decode
    // a read and a write in one cycle both act; the read sees the old value
    logic sel_control;
    logic sel_status;
    logic sel_fc_count;
    logic sel_rx_count;
    logic wr_control;
    logic wr_status;
    logic rd_status;
    logic rd_fc_count;
    logic rd_rx_count;

    assign sel_control  = (reg_addr == `OFS_INTERRUPT_CONTROL);
    assign sel_status   = (reg_addr == `OFS_EVENT_STATUS);
    assign sel_fc_count = (reg_addr == `OFS_FALSE_CARRIER_CNT);
    assign sel_rx_count = (reg_addr == `OFS_RX_ERROR_CNT);
    assign wr_control   = reg_wr & sel_control;
    assign wr_status    = reg_wr & sel_status;
    assign rd_status    = reg_rd & sel_status;
    assign rd_fc_count  = reg_rd & sel_fc_count;
    assign rd_rx_count  = reg_rd & sel_rx_count;

    // control register
    logic [`CTRL_FIELD_WIDTH-1:0] control_reg;
    logic [`CTRL_FIELD_WIDTH-1:0] control_next;
    logic                         test_irq_force;
    logic                         global_event_irq_enable;
    logic                         output_enable;

    // only the three low bits have storage; the rest cannot be written
    assign control_next = wr_control ?
        reg_wdata[`CTRL_FIELD_WIDTH-1:0] : control_reg;

    assign test_irq_force          = control_reg[`CTRL_TEST_FORCE_BIT];
    assign global_event_irq_enable = control_reg[`CTRL_GLOBAL_ENABLE_BIT];
    assign output_enable           = control_reg[`CTRL_OUTPUT_ENABLE_BIT];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            control_reg <= `CTRL_RESET;
        end else begin
            control_reg <= control_next;
        end
    end

    // per-event enables
    phy_irq_pkg::event_vec_type enable_reg;
    phy_irq_pkg::event_vec_type enable_next;

    // bit 7 and the pending field are not stored from the write data
    assign enable_next = wr_status ?
        reg_wdata[`STATUS_ENABLE_LSB +: `EVENT_COUNT] : enable_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= `EVENT_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // error counters
    // each count clears on its own read, never on the status read
    logic [`COUNT_WIDTH-1:0] false_carrier_count;
    logic [`COUNT_WIDTH-1:0] rx_error_count;
    logic                    false_carrier_half;
    logic                    rx_error_half;

    event_counter #(
        .WIDTH     (`COUNT_WIDTH)
    ) u_false_carrier_counter (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .inc       (false_carrier_event),
        .clr       (rd_fc_count),
        .count     (false_carrier_count),
        .half_rise (false_carrier_half)
    );

    event_counter #(
        .WIDTH     (`COUNT_WIDTH)
    ) u_rx_error_counter (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .inc       (rx_error_event),
        .clr       (rd_rx_count),
        .count     (rx_error_count),
        .half_rise (rx_error_half)
    );

    // event detection
    // previous levels are taken on the first edge after reset, so a link
    // already up at release does not look like a change
    logic primed_reg;
    logic energy_prev_reg;
    logic link_prev_reg;
    logic speed_prev_reg;
    logic duplex_prev_reg;
    logic autoneg_prev_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            primed_reg       <= 1'b0;
            energy_prev_reg  <= 1'b0;
            link_prev_reg    <= 1'b0;
            speed_prev_reg   <= 1'b0;
            duplex_prev_reg  <= 1'b0;
            autoneg_prev_reg <= 1'b0;
        end else begin
            primed_reg       <= 1'b1;
            energy_prev_reg  <= energy_state;
            link_prev_reg    <= link_state;
            speed_prev_reg   <= speed_state;
            duplex_prev_reg  <= duplex_state;
            autoneg_prev_reg <= autoneg_done;
        end
    end

    phy_irq_pkg::event_vec_type event_hit;

    // a level source reports a change on either edge once primed
    function automatic logic level_changed(input logic now_level,
                                           input logic prev_level,
                                           input logic primed);
        return primed & (now_level ^ prev_level);
    endfunction

    always_comb begin
        event_hit = '0;
        event_hit[`EV_ENERGY]  = level_changed(energy_state,
            energy_prev_reg, primed_reg);
        event_hit[`EV_LINK]    = level_changed(link_state,
            link_prev_reg, primed_reg);
        event_hit[`EV_SPEED]   = level_changed(speed_state,
            speed_prev_reg, primed_reg);
        event_hit[`EV_DUPLEX]  = level_changed(duplex_state,
            duplex_prev_reg, primed_reg);
        // autoneg counts only its rising edge; dropping back is no event
        event_hit[`EV_AUTONEG] = primed_reg &
            autoneg_done & ~autoneg_prev_reg;
        event_hit[`EV_FALSE_CARRIER_HALF] = false_carrier_half;
        event_hit[`EV_RX_ERROR_HALF]      = rx_error_half;
    end

    // pending status
    phy_irq_pkg::event_vec_type pending_reg;
    phy_irq_pkg::event_vec_type pending_next;
    phy_irq_pkg::event_vec_type pending_kept;

    // a read clears what it reports; a new hit wins over the clear
    assign pending_kept = rd_status ? '0 : pending_reg;
    assign pending_next = pending_kept | event_hit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_reg <= `EVENT_RESET;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // read back
    phy_irq_pkg::reg_word_type control_word;
    phy_irq_pkg::reg_word_type status_word;
    phy_irq_pkg::reg_word_type read_word;
    phy_irq_pkg::reg_word_type rdata_reg;
    logic                      rvalid_reg;

    // unstored bits are tied low so reserved fields always read zero
    assign control_word = {13'h0000, control_reg};
    assign status_word  = {1'b0, pending_reg, 1'b0, enable_reg};

    // a count sits in the low bits of the register word
    function automatic phy_irq_pkg::reg_word_type count_word(
        input logic [`COUNT_WIDTH-1:0] count_value);
        return {{(`DATA_WIDTH - `COUNT_WIDTH){1'b0}}, count_value};
    endfunction

    always_comb begin
        if (sel_control) begin
            read_word = control_word;
        end else if (sel_status) begin
            read_word = status_word;
        end else if (sel_fc_count) begin
            read_word = count_word(false_carrier_count);
        end else if (sel_rx_count) begin
            read_word = count_word(rx_error_count);
        end else begin
            read_word = 16'h0000;
        end
    end

    // rdata stands until the next read for a master that samples late
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= read_word;
            end
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // interrupt level
    // registered so the pin cannot glitch while pending and enables settle
    logic any_enabled_event;
    logic irq_next;
    logic irq_reg;

    assign any_enabled_event = |(pending_reg & enable_reg);
    // test force ignores the event state; events need both enables
    assign irq_next = test_irq_force |
        (any_enabled_event & global_event_irq_enable &
         output_enable);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign irq_active = irq_reg;

    // shared pin
    logic pin_level;
    logic pd_level_reg;

    input_sync u_pin_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (powerdown_or_irq_pin_i),
        .sync_out (pin_level)
    );

    // the pin reads back our own drive while an output, so power-down
    // is only honoured in input mode
    assign powerdown_or_irq_pin_oe = output_enable;
    assign powerdown_or_irq_pin_o  = IRQ_ACTIVE_LOW ? ~irq_reg : irq_reg;

    // a registered level; for a few cycles after leaving output mode
    // the synchroniser still holds the level that we drove
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_level_reg <= 1'b0;
        end else begin
            pd_level_reg <= ~pin_level;
        end
    end

    assign powerdown_request = ~output_enable & pd_level_reg;
endmodule // phy_event_interrupt_logic

//--- tb/pin_board.sv
// board model of the shared power-down / interrupt pin with its pull-up
module pin_board (
    input  wire logic pin_o,     // device drive value
    input  wire logic pin_oe,    // device drives the pin
    input  wire logic pd_hold,   // external switch pulls the line low
    output logic      pin_level  // resolved wire level
);
    timeunit 1ns;
    timeprecision 1ns;
    // the switch is open-drain, so a released line floats up to the pull-up
    assign pin_level = pin_oe ? pin_o : !pd_hold;
endmodule // pin_board

//--- tb/phy_irq_chk.sv
// port assertions of the interrupt logic
`include "phy_irq_defs.svh"
module irq_chk (
    input wire logic                      core_clk,   // clock
    input wire logic                      arst_n,     // reset, low
    input wire phy_irq_pkg::reg_addr_type reg_addr,   // index
    input wire logic                      reg_rd,     // read
    input wire logic                      reg_wr,     // write
    input wire phy_irq_pkg::reg_word_type reg_wdata,  // write data
    input wire phy_irq_pkg::reg_word_type reg_rdata,  // read data
    input wire logic                      reg_rvalid, // read done
    input wire logic                      powerdown_or_irq_pin_o,  // pin
    input wire logic                      powerdown_or_irq_pin_oe, // drive
    input wire logic                      powerdown_request, // pin asks
    input wire logic                      irq_active  // irq level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ctrl_wr;
    assign ctrl_wr = reg_wr && reg_addr == `OFS_INTERRUPT_CONTROL;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read answer missing");
    spurious_valid_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without read");
    test_force_a: assert property (
        ctrl_wr && reg_wdata[2] |=> ##1 irq_active)
        else $error("test force did not raise irq");
    global_off_a: assert property (
        ctrl_wr && reg_wdata[2:0] == 3'h0 |=> ##1 !irq_active)
        else $error("irq with all control bits clear");
    pin_role_a: assert property (
        ctrl_wr |=> powerdown_or_irq_pin_oe == $past(reg_wdata[0]))
        else $error("pin drive does not follow control");
    pin_level_a: assert property (
        powerdown_or_irq_pin_oe |-> powerdown_or_irq_pin_o == !irq_active)
        else $error("pin value differs from irq");
    pd_input_a: assert property (
        powerdown_request |-> !powerdown_or_irq_pin_oe)
        else $error("power-down taken while pin is output");
    ctrl_zero_a: assert property (
        reg_rd && reg_addr == `OFS_INTERRUPT_CONTROL
        |=> reg_rdata[15:3] == 13'h0000)
        else $error("control upper bits not zero");
    status_rsvd_a: assert property (
        reg_rd && reg_addr == `OFS_EVENT_STATUS
        |=> !reg_rdata[15] && !reg_rdata[7])
        else $error("status reserved bits not zero");
    cover property (ctrl_wr && reg_wdata[2]);
    cover property (powerdown_request);
    cover property (reg_rvalid && reg_rdata[14:8] != 7'h00);
endmodule // irq_chk

//--- tb/phy_event_interrupt_logic_tb_top.sv
// self-checking bench of the interrupt logic
`include "phy_irq_defs.svh"
module phy_event_interrupt_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                       core_clk;
    logic                       arst_n;
    phy_irq_pkg::reg_addr_type  reg_addr;
    logic                       reg_rd;
    logic                       reg_wr;
    phy_irq_pkg::reg_word_type  reg_wdata;
    phy_irq_pkg::reg_word_type  reg_rdata;
    logic                       reg_rvalid;
    phy_irq_pkg::event_vec_type ev;
    logic                       pin_i;
    logic                       pin_o;
    logic                       pin_oe;
    logic                       pd_hold;
    logic                       pd_req;
    logic                       irq;
    int                         errors;
    int                         checks;
    phy_irq_pkg::reg_word_type  expq[$];

    phy_event_interrupt_logic uut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .energy_state(ev[`EV_ENERGY]), .link_state(ev[`EV_LINK]),
        .speed_state(ev[`EV_SPEED]), .duplex_state(ev[`EV_DUPLEX]),
        .autoneg_done(ev[`EV_AUTONEG]),
        .false_carrier_event(ev[`EV_FALSE_CARRIER_HALF]),
        .rx_error_event(ev[`EV_RX_ERROR_HALF]),
        .powerdown_or_irq_pin_i(pin_i), .powerdown_or_irq_pin_o(pin_o),
        .powerdown_or_irq_pin_oe(pin_oe), .powerdown_request(pd_req),
        .irq_active(irq));
    pin_board board (.pin_o(pin_o), .pin_oe(pin_oe), .pd_hold(pd_hold),
        .pin_level(pin_i));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic cmp16(input phy_irq_pkg::reg_word_type got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s is %b", $time, what, got);
        end
    endtask
    task automatic wr(input phy_irq_pkg::reg_addr_type a,
                      input phy_irq_pkg::reg_word_type d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        // one idle cycle, so a strobe is never lowered and raised at once
        @(negedge core_clk);
    endtask
    task automatic rd(input phy_irq_pkg::reg_addr_type a,
                      input phy_irq_pkg::reg_word_type e);
        expq.push_back(e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic pulses(input int idx, input int n);
        ev[idx] = 1'b1;
        repeat (n) @(negedge core_clk);
        ev[idx] = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // read answers are judged where they appear, in request order
    always @(negedge core_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                errors++;
                $display("mismatch at %0t: unexpected read answer", $time);
            end else begin
                cmp16(reg_rdata, expq.pop_front());
            end
        end
    end

    initial begin
        #3_000_000;
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        logic [2:0]                 c;
        phy_irq_pkg::event_vec_type en;
        int                         idx;
        logic                       exp;
        phy_irq_pkg::reg_word_type  st;
        errors = 0;
        checks = 0;
        arst_n = 1'b0;
        reg_addr = 5'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        ev = 7'h00;
        pd_hold = 1'b0;
        void'($urandom(32'h3030_af35));
        repeat (5) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        rd(`OFS_INTERRUPT_CONTROL, 16'h0000);
        rd(`OFS_EVENT_STATUS, 16'h0000);
        rd(5'h1F, 16'h0000);
        wr(`OFS_INTERRUPT_CONTROL, 16'hFFFF);
        rd(`OFS_INTERRUPT_CONTROL, 16'h0007);
        wr(`OFS_EVENT_STATUS, 16'hFFFF);
        rd(`OFS_EVENT_STATUS, 16'h007F);
        // every control code, random enables and a random level event
        for (int k = 0; k < 16; k++) begin
            c = k[2:0];
            en = 7'($urandom);
            idx = $urandom_range(6, 2);
            wr(`OFS_EVENT_STATUS, {9'h000, en});
            wr(`OFS_INTERRUPT_CONTROL, {13'h0000, c});
            if (idx == `EV_AUTONEG) begin
                ev[idx] = 1'b0;
                @(negedge core_clk);
            end
            ev[idx] = ~ev[idx];
            repeat (3) @(negedge core_clk);
            exp = c[2] | (c[1] & c[0] & en[idx]);
            cmp1(irq, exp, "irq");
            cmp1(pin_oe, c[0], "pin drive");
            if (c[0]) cmp1(pin_i, ~exp, "pin level");
            st = (16'h0001 << (`STATUS_PENDING_LSB + idx)) | {9'h000, en};
            rd(`OFS_EVENT_STATUS, st);
            repeat (3) @(negedge core_clk);
            cmp1(irq, c[2], "irq after clear");
        end
        // event landing on the clearing read must survive it
        ev[`EV_DUPLEX] = ~ev[`EV_DUPLEX];
        rd(`OFS_EVENT_STATUS, {9'h000, en});
        rd(`OFS_EVENT_STATUS, 16'h0800 | {9'h000, en});
        pulses(`EV_FALSE_CARRIER_HALF, 127);
        rd(`OFS_EVENT_STATUS, {9'h000, en});
        pulses(`EV_FALSE_CARRIER_HALF, 1);
        rd(`OFS_EVENT_STATUS, 16'h0200 | {9'h000, en});
        rd(`OFS_FALSE_CARRIER_CNT, 16'h0080);
        rd(`OFS_FALSE_CARRIER_CNT, 16'h0000);
        pulses(`EV_RX_ERROR_HALF, 300);
        rd(`OFS_RX_ERROR_CNT, 16'h00FF);
        rd(`OFS_EVENT_STATUS, 16'h0100 | {9'h000, en});
        wr(`OFS_INTERRUPT_CONTROL, 16'h0000);
        pd_hold = 1'b1;
        repeat (8) @(negedge core_clk);
        cmp1(pd_req, 1'b1, "power-down");
        pd_hold = 1'b0;
        repeat (8) @(negedge core_clk);
        cmp1(pd_req, 1'b0, "power-down");
        wr(`OFS_INTERRUPT_CONTROL, 16'h0001);
        pd_hold = 1'b1;
        repeat (8) @(negedge core_clk);
        cmp1(pd_req, 1'b0, "power-down as output");
        repeat (4) @(negedge core_clk);
        if (expq.size() != 0) begin
            errors++;
            $display("mismatch at %0t: read answers missing", $time);
        end
        summarize();
    end
endmodule // phy_event_interrupt_logic_tb_top

bind phy_event_interrupt_logic irq_chk chk (.core_clk, .arst_n, .reg_addr,
    .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .powerdown_or_irq_pin_o, .powerdown_or_irq_pin_oe, .powerdown_request,
    .irq_active);
